// ---- src/pch_cfg_pkg.sv ----
package pch_cfg_pkg;

  // Configuration byte offsets
  localparam logic [7:0] OFF_IDENTITY = 8'h00;
  localparam logic [7:0] OFF_CMD_STATUS = 8'h04;
  localparam logic [7:0] OFF_CLASS_REV = 8'h08;

  // Command half bit positions
  localparam int BIT_IO_SPACE = 0;
  localparam int BIT_MEM_SPACE = 1;
  localparam int BIT_BUS_MASTER = 2;
  localparam int BIT_SPECIAL_CYCLE = 3;
  localparam int BIT_WRITE_INVALIDATE = 4;
  localparam int BIT_PALETTE_SNOOP = 5;
  localparam int BIT_PARITY_RESPONSE = 6;
  localparam int BIT_STEPPING = 7;
  localparam int BIT_SYSTEM_ERROR_EN = 8;
  localparam int BIT_FAST_B2B_EN = 9;

  // Status half bit positions
  localparam int BIT_HIGH_SPEED = 21;
  localparam int BIT_FAST_B2B_CAP = 23;
  localparam int BIT_DATA_PARITY_REP = 24;
  localparam int BIT_SELECT_TIMING_LO = 25;
  localparam int BIT_SIG_TARGET_ABORT = 27;
  localparam int BIT_RCV_TARGET_ABORT = 28;
  localparam int BIT_RCV_MASTER_ABORT = 29;
  localparam int BIT_SIG_SYSTEM_ERROR = 30;
  localparam int BIT_DET_PARITY_ERROR = 31;

  // Fixed field values
  localparam logic [1:0] SELECT_TIMING_MEDIUM = 2'h1;
  localparam logic [7:0] CLASS_BASE_NETWORK = 8'h02;
  localparam logic [7:0] CLASS_SUB_OTHER = 8'h80;
  localparam logic [7:0] CLASS_PROG_IF = 8'h00;

  // Values after reset
  localparam logic RESET_CMD_BIT = 1'b0;
  localparam logic RESET_STATUS_BIT = 1'b0;
  localparam logic [31:0] RESET_READ_DATA = 32'h0000_0000;

  // Latency of a configuration answer in clock cycles
  localparam int CFG_ANSWER_CYCLES = 1;

endpackage

// ---- src/pch_cfg_regs.sv ----
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Registers are read or written only during a selected configuration cycle.
// - Writes to unused bits do nothing; host writes zeros and does not mask reads.
// - Every writable bit clears to zero at reset.
// - Writes to read-only positions change neither values nor operation.
// - Offset zero returns part identifier high, maker identifier low, read-only.
// - With all command bits zero only configuration accesses are served.
// - Status bits read normally; writing one clears, writes never set.
// - Memory accesses are answered only while memory space enable is one.
// - Bus mastering is allowed only while bus master enable is one.
// - I/O, special cycle, write-invalidate, snoop, stepping, fast enable read zero.
// - Parity errors are reported only while parity response enable is one.
// - System error drives only when enabled; address parity needs both enables.
// - High speed capable and fast back-to-back capable read as one.
// - Data parity reported sets on initiator parity signalling with response enabled.
// - Select timing field is read-only and reads medium timing.
// - Signalled target abort sets when the device target-aborts; sticky.
// - Received target abort sets when own transaction is target-aborted; sticky.
// - Received master abort sets on own master abort except special cycles.
// - Signalled system error sets whenever the system error output asserts.
// - Detected parity error sets on every detected parity error; sticky.
// - Offset eight is read-only class code and revision identifier.
// - Class code says network controller, sub-class other controller.
module pch_cfg_regs #(
  parameter logic [15:0] PART_ID = 16'hA5A5, // Value is arbitrary
  parameter logic [15:0] MAKER_ID = 16'h5A5A, // Value is arbitrary
  parameter logic [7:0] REVISION_ID = 8'h01 // Value is arbitrary
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Configuration access from the target machine
  input wire logic cfg_select,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_byte_en,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_done,
  // Bus events from master and target machines
  input wire logic evt_parity_detected,
  input wire logic evt_addr_parity,
  input wire logic evt_initiator_parity,
  input wire logic evt_target_abort_sent,
  input wire logic evt_target_abort_rcvd,
  input wire logic evt_master_abort,
  input wire logic evt_special_cycle,
  input wire logic evt_system_error_req,
  // Controls to master and target machines
  output logic memory_space_enable,
  output logic bus_master_enable,
  output logic parity_response_enable,
  output logic system_error_enable,
  output logic parity_report_allowed,
  // System error open-drain pin
  output logic system_error_out_n,
  output logic system_error_oe
);

  typedef struct packed {
    logic mem_en;
    logic master_en;
    logic parity_en;
    logic syserr_en;
    logic det_parity;
    logic sig_syserr;
    logic rcv_mabort;
    logic rcv_tabort;
    logic sig_tabort;
    logic data_parity;
    logic syserr_drive;
    logic syserr_out_n;
    logic parity_report;
    logic done;
    logic [31:0] rdata;
  } pch_state_s;

  pch_state_s state_reg;
  pch_state_s state_next;

  logic any_write;
  logic any_read;
  logic cmd_write;
  logic [15:0] status_clear;
  logic syserr_now;

  if (MAKER_ID == 16'hFFFF) begin
    $error("Maker identifier of all ones marks an absent device");
  end

  function automatic logic [31:0] status_word(input pch_state_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[pch_cfg_pkg::BIT_DET_PARITY_ERROR] = s.det_parity;
    w[pch_cfg_pkg::BIT_SIG_SYSTEM_ERROR] = s.sig_syserr;
    w[pch_cfg_pkg::BIT_RCV_MASTER_ABORT] = s.rcv_mabort;
    w[pch_cfg_pkg::BIT_RCV_TARGET_ABORT] = s.rcv_tabort;
    w[pch_cfg_pkg::BIT_SIG_TARGET_ABORT] = s.sig_tabort;
    w[pch_cfg_pkg::BIT_SELECT_TIMING_LO +: 2] = pch_cfg_pkg::SELECT_TIMING_MEDIUM;
    w[pch_cfg_pkg::BIT_DATA_PARITY_REP] = s.data_parity;
    w[pch_cfg_pkg::BIT_FAST_B2B_CAP] = 1'b1;
    w[pch_cfg_pkg::BIT_HIGH_SPEED] = 1'b1;
    w[pch_cfg_pkg::BIT_SYSTEM_ERROR_EN] = s.syserr_en;
    w[pch_cfg_pkg::BIT_PARITY_RESPONSE] = s.parity_en;
    w[pch_cfg_pkg::BIT_BUS_MASTER] = s.master_en;
    w[pch_cfg_pkg::BIT_MEM_SPACE] = s.mem_en;
    // I/O, special cycle, invalidate, snoop, stepping and fast enable stay zero
    return w;
  endfunction

  function automatic logic [31:0] read_word(input pch_state_s s, input logic [7:0] addr);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (addr[7:2])
      pch_cfg_pkg::OFF_IDENTITY[7:2]: begin
        w = {PART_ID, MAKER_ID};
      end
      pch_cfg_pkg::OFF_CMD_STATUS[7:2]: begin
        w = status_word(s);
      end
      pch_cfg_pkg::OFF_CLASS_REV[7:2]: begin
        w = {pch_cfg_pkg::CLASS_BASE_NETWORK, pch_cfg_pkg::CLASS_SUB_OTHER,
             pch_cfg_pkg::CLASS_PROG_IF, REVISION_ID};
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  // Access qualification
  always_comb begin
    any_write = cfg_select && cfg_write && (cfg_byte_en != 4'h0);
    any_read = cfg_select && !cfg_write;
    cmd_write = any_write && (cfg_addr[7:2] == pch_cfg_pkg::OFF_CMD_STATUS[7:2]);
    status_clear = 16'h0000;
    if (cmd_write) begin
      status_clear[7:0] = cfg_byte_en[2] ? cfg_wdata[23:16] : 8'h00;
      status_clear[15:8] = cfg_byte_en[3] ? cfg_wdata[31:24] : 8'h00;
    end
    syserr_now = state_reg.syserr_en &&
                 (evt_system_error_req || (evt_addr_parity && state_reg.parity_en));
  end

  always_comb begin
    state_next = state_reg;
    state_next.done = any_write || any_read;
    state_next.rdata = any_read ? read_word(state_reg, cfg_addr) : state_reg.rdata;
    // Only the four writable command bits take data
    if (cmd_write && cfg_byte_en[0]) begin
      state_next.mem_en = cfg_wdata[pch_cfg_pkg::BIT_MEM_SPACE];
      state_next.master_en = cfg_wdata[pch_cfg_pkg::BIT_BUS_MASTER];
      state_next.parity_en = cfg_wdata[pch_cfg_pkg::BIT_PARITY_RESPONSE];
    end
    if (cmd_write && cfg_byte_en[1]) begin
      state_next.syserr_en = cfg_wdata[pch_cfg_pkg::BIT_SYSTEM_ERROR_EN];
    end
    // Sticky flags: a new event wins over a clear in the same cycle
    state_next.det_parity = (state_reg.det_parity && !status_clear[15]) ||
                            evt_parity_detected || evt_addr_parity;
    state_next.sig_syserr = (state_reg.sig_syserr && !status_clear[14]) ||
                            syserr_now;
    state_next.rcv_mabort = (state_reg.rcv_mabort && !status_clear[13]) ||
                            (evt_master_abort && !evt_special_cycle);
    state_next.rcv_tabort = (state_reg.rcv_tabort && !status_clear[12]) ||
                            evt_target_abort_rcvd;
    state_next.sig_tabort = (state_reg.sig_tabort && !status_clear[11]) ||
                            evt_target_abort_sent;
    state_next.data_parity = (state_reg.data_parity && !status_clear[8]) ||
                             (evt_initiator_parity && state_reg.parity_en);
    state_next.syserr_drive = syserr_now;
    state_next.syserr_out_n = !syserr_now;
    state_next.parity_report = state_reg.parity_en && evt_parity_detected;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg.mem_en <= pch_cfg_pkg::RESET_CMD_BIT;
      state_reg.master_en <= pch_cfg_pkg::RESET_CMD_BIT;
      state_reg.parity_en <= pch_cfg_pkg::RESET_CMD_BIT;
      state_reg.syserr_en <= pch_cfg_pkg::RESET_CMD_BIT;
      state_reg.det_parity <= pch_cfg_pkg::RESET_STATUS_BIT;
      state_reg.sig_syserr <= pch_cfg_pkg::RESET_STATUS_BIT;
      state_reg.rcv_mabort <= pch_cfg_pkg::RESET_STATUS_BIT;
      state_reg.rcv_tabort <= pch_cfg_pkg::RESET_STATUS_BIT;
      state_reg.sig_tabort <= pch_cfg_pkg::RESET_STATUS_BIT;
      state_reg.data_parity <= pch_cfg_pkg::RESET_STATUS_BIT;
      state_reg.syserr_drive <= 1'b0;
      state_reg.syserr_out_n <= 1'b1;
      state_reg.parity_report <= 1'b0;
      state_reg.done <= 1'b0;
      state_reg.rdata <= pch_cfg_pkg::RESET_READ_DATA;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign cfg_rdata = state_reg.rdata;
  assign cfg_done = state_reg.done;
  assign memory_space_enable = state_reg.mem_en;
  assign bus_master_enable = state_reg.master_en;
  assign parity_response_enable = state_reg.parity_en;
  assign system_error_enable = state_reg.syserr_en;
  assign parity_report_allowed = state_reg.parity_report;
  assign system_error_out_n = state_reg.syserr_out_n;
  assign system_error_oe = state_reg.syserr_drive;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_cmd_write_one(int bitpos);
    cmd_write && cfg_byte_en[0] && cfg_wdata[bitpos];
  endsequence

  sequence s_status_clear_top;
    cmd_write && cfg_byte_en[3] && cfg_wdata[31] && !evt_parity_detected && !evt_addr_parity;
  endsequence

  chk_idle_no_access: assert property (!cfg_select |=> !cfg_done)
    else $error("Answer given without a selected configuration cycle");

  chk_identity_read: assert property (
    any_read && cfg_addr[7:2] == 6'h00 |=> cfg_rdata == {PART_ID, MAKER_ID})
    else $error("Identity read returned wrong value");

  chk_class_read: assert property (
    any_read && cfg_addr[7:2] == 6'h02 |=> cfg_rdata == {8'h02, 8'h80, 8'h00, REVISION_ID})
    else $error("Class and revision read returned wrong value");

  chk_fixed_status_bits: assert property (
    any_read && cfg_addr[7:2] == 6'h01 |=>
      cfg_rdata[26:25] == 2'h1 && cfg_rdata[23:21] == 3'h5 &&
      cfg_rdata[20:10] == 11'h000 &&
      cfg_rdata[9] == 1'b0 && cfg_rdata[7] == 1'b0 &&
      cfg_rdata[5:3] == 3'b000 && cfg_rdata[0] == 1'b0)
    else $error("Hardwired status or command bits read wrong");

  chk_unmapped_zero: assert property (
    any_read && cfg_addr[7:2] > 6'h02 |=> cfg_rdata == 32'h0000_0000)
    else $error("Unmapped configuration offset read nonzero");

  chk_mem_enable_set: assert property (
    s_cmd_write_one(pch_cfg_pkg::BIT_MEM_SPACE) |=> memory_space_enable)
    else $error("Memory space enable did not follow write");

  chk_master_enable_set: assert property (
    cmd_write && cfg_byte_en[0] |=> bus_master_enable == $past(cfg_wdata[2]))
    else $error("Bus master enable did not follow write");

  chk_status_sticky: assert property (
    state_reg.sig_tabort && !(cmd_write && cfg_byte_en[3] && cfg_wdata[27])
      |=> state_reg.sig_tabort)
    else $error("Signalled target abort dropped without a clear");

  chk_status_clear: assert property (
    state_reg.det_parity ##0 s_status_clear_top |=> !state_reg.det_parity)
    else $error("Writing one did not clear detected parity error");

  chk_no_write_set: assert property (
    !state_reg.rcv_tabort && !evt_target_abort_rcvd |=> !state_reg.rcv_tabort)
    else $error("Received target abort set without an event");

  chk_master_abort: assert property (
    evt_master_abort && !evt_special_cycle |=> state_reg.rcv_mabort)
    else $error("Master abort not recorded");

  chk_syserr_gate: assert property (
    system_error_oe |-> $past(state_reg.syserr_en) &&
      ($past(evt_system_error_req) || ($past(evt_addr_parity) && $past(state_reg.parity_en))))
    else $error("System error driven without enable");

  chk_syserr_records: assert property (system_error_oe |-> state_reg.sig_syserr)
    else $error("System error asserted but not recorded");

  chk_parity_detect: assert property (evt_parity_detected |=> state_reg.det_parity)
    else $error("Detected parity error not recorded");

  chk_data_parity: assert property (
    evt_initiator_parity && !state_reg.parity_en && !state_reg.data_parity |=>
      !state_reg.data_parity)
    else $error("Data parity reported set with response disabled");

  chk_report_gate: assert property (parity_report_allowed |-> $past(state_reg.parity_en))
    else $error("Parity error reported with response disabled");

  chk_ro_write_ignored: assert property (
    any_write && cfg_addr[7:2] != 6'h01 |=> $stable(memory_space_enable) &&
      $stable(bus_master_enable) && $stable(system_error_enable))
    else $error("Write to read-only register changed command state");

  chk_tabort_sent_set: assert property (
    evt_target_abort_sent |=> state_reg.sig_tabort)
    else $error("Signalled target abort not recorded");

  chk_tabort_rcvd_set: assert property (
    evt_target_abort_rcvd |=> state_reg.rcv_tabort)
    else $error("Received target abort not recorded");

  chk_special_masked: assert property (
    evt_master_abort && evt_special_cycle && !state_reg.rcv_mabort |=> !state_reg.rcv_mabort)
    else $error("Master abort recorded during special cycle");

  chk_data_parity_set: assert property (
    evt_initiator_parity && state_reg.parity_en |=> state_reg.data_parity)
    else $error("Data parity reported not recorded");

  chk_syserr_request: assert property (
    evt_system_error_req && state_reg.syserr_en |=> system_error_oe && !system_error_out_n)
    else $error("Enabled system error request not driven");

  chk_pin_pair: assert property (
    system_error_oe != system_error_out_n)
    else $error("System error pin level and enable disagree");

  chk_parity_en_set: assert property (
    cmd_write && cfg_byte_en[0] |=>
      parity_response_enable == $past(cfg_wdata[pch_cfg_pkg::BIT_PARITY_RESPONSE]))
    else $error("Parity response enable did not follow write");

  chk_syserr_en_set: assert property (
    cmd_write && cfg_byte_en[1] |=>
      system_error_enable == $past(cfg_wdata[pch_cfg_pkg::BIT_SYSTEM_ERROR_EN]))
    else $error("System error enable did not follow write");

  chk_read_answer: assert property (
    any_read |=> cfg_done)
    else $error("Selected read not answered");

  chk_write_answer: assert property (
    any_write |=> cfg_done)
    else $error("Selected write not answered");

endmodule

`default_nettype wire

// ---- test/pch_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module pch_host_model (
  // Clock
  input wire logic clk,
  // Configuration access to the device
  output logic cfg_select,
  output logic cfg_write,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_byte_en,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_done
);
  // Reserved positions of the command and status word
  localparam logic [31:0] RSVD_MASK = 32'h005F_FC00;

  initial begin
    cfg_select = 1'b0;
    cfg_write = 1'b0;
    cfg_addr = 8'h00;
    cfg_byte_en = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end

  // One access per call; answer taken one cycle after the request
  task automatic access(input logic sel, input logic wr, input logic [7:0] addr,
      input logic [3:0] be, input logic [31:0] wd, output logic ok, output logic [31:0] rd);
    @(posedge clk);
    #1;
    cfg_select = sel;
    cfg_write = wr;
    cfg_addr = addr;
    cfg_byte_en = be;
    // Reserved bits carry zeros while the request is on the lines
    cfg_wdata = wd & ~RSVD_MASK;
    @(posedge clk);
    #1;
    ok = cfg_done;
    rd = cfg_rdata;
    // Released lines show garbage, not the last value
    cfg_select = 1'b0;
    cfg_write = ~wr;
    cfg_addr = ~addr;
    cfg_byte_en = ~be;
    cfg_wdata = ~wd;
  endtask
endmodule
`default_nettype wire

// ---- test/pci_config_header_regs_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module pci_config_header_regs_tb_top;
  localparam logic [15:0] T_PART = 16'h3C3C; // Value is arbitrary
  localparam logic [15:0] T_MAKER = 16'hC3C3; // Value is arbitrary
  localparam logic [7:0] T_REV = 8'h5E; // Value is arbitrary
  localparam logic [31:0] ST0 = 32'h02A0_0000;
  localparam logic [7:0] CS = pch_cfg_pkg::OFF_CMD_STATUS;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [6:0] evt = 7'h00;
  logic special = 1'b0;
  int n_fail = 0;
  int compares = 0;
  wire logic sel, wr, done, mem_en, mst_en, rsp_en, se_en, rpt, se_out_n, se_oe;
  wire logic [7:0] addr;
  wire logic [3:0] be;
  wire logic [31:0] wdata, rdata;

  pch_host_model i_pch_host_model (.clk(clk), .cfg_select(sel), .cfg_write(wr),
    .cfg_addr(addr), .cfg_byte_en(be), .cfg_wdata(wdata), .cfg_rdata(rdata),
    .cfg_done(done));
  pch_cfg_regs #(.PART_ID(T_PART), .MAKER_ID(T_MAKER), .REVISION_ID(T_REV)) i_pch_cfg_regs (
    .clk(clk), .reset(reset), .cfg_select(sel), .cfg_write(wr), .cfg_addr(addr),
    .cfg_byte_en(be), .cfg_wdata(wdata), .cfg_rdata(rdata), .cfg_done(done),
    .evt_parity_detected(evt[0]), .evt_addr_parity(evt[1]), .evt_initiator_parity(evt[2]),
    .evt_target_abort_sent(evt[3]), .evt_target_abort_rcvd(evt[4]),
    .evt_master_abort(evt[5]), .evt_special_cycle(special), .evt_system_error_req(evt[6]),
    .memory_space_enable(mem_en), .bus_master_enable(mst_en),
    .parity_response_enable(rsp_en), .system_error_enable(se_en),
    .parity_report_allowed(rpt), .system_error_out_n(se_out_n), .system_error_oe(se_oe));

  always #20 clk = ~clk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic ok;
    logic [31:0] d;
    i_pch_host_model.access(1'b1, 1'b0, a, 4'h0, 32'h0, ok, d);
    check(ok, 1, "read done");
    check(d, exp, "read data");
  endtask

  task automatic wt(input logic s, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    logic ok;
    logic [31:0] r;
    i_pch_host_model.access(s, 1'b1, a, b, d, ok, r);
    check(ok, s && b != 4'h0, "write done");
  endtask

  task automatic pulse(input logic [6:0] m);
    @(posedge clk);
    #1;
    evt = m;
    @(posedge clk);
    #1;
    evt = 7'h00;
  endtask

  task automatic t_reset();
    rd(pch_cfg_pkg::OFF_IDENTITY, {T_PART, T_MAKER});
    rd(CS, ST0);
    rd(pch_cfg_pkg::OFF_CLASS_REV, {8'h02, 8'h80, 8'h00, T_REV});
    rd(8'h0C, 32'h0);
    check({mem_en, mst_en, rsp_en, se_en, se_oe, se_out_n}, 1, "reset outputs");
    $display("test reset_values done");
  endtask

  task automatic t_command();
    wt(1'b1, pch_cfg_pkg::OFF_IDENTITY, 4'hF, 32'hFFFF_FFFF);
    wt(1'b1, pch_cfg_pkg::OFF_CLASS_REV, 4'hF, 32'hFFFF_FFFF);
    rd(pch_cfg_pkg::OFF_IDENTITY, {T_PART, T_MAKER});
    rd(pch_cfg_pkg::OFF_CLASS_REV, {8'h02, 8'h80, 8'h00, T_REV});
    wt(1'b1, CS, 4'hF, 32'hFFA0_03FF);
    rd(CS, ST0 | 32'h146);
    check({mem_en, mst_en, rsp_en, se_en}, 4'hF, "enables on");
    wt(1'b0, CS, 4'hF, 32'h0);
    wt(1'b1, CS, 4'h0, 32'h0);
    rd(CS, ST0 | 32'h146);
    wt(1'b1, CS, 4'h1, 32'h0);
    rd(CS, ST0 | 32'h100);
    wt(1'b1, CS, 4'hF, 32'h0);
    rd(CS, ST0);
    check({mem_en, mst_en, rsp_en, se_en}, 4'h0, "enables off");
    $display("test command done");
  endtask

  task automatic t_status();
    wt(1'b1, CS, 4'h1, 32'h40);
    pulse(7'h3D);
    check(rpt, 1, "report allowed");
    rd(CS, 32'hBBA0_0040);
    wt(1'b1, CS, 4'hC, 32'h2800_0000);
    rd(CS, 32'h93A0_0040);
    wt(1'b1, CS, 4'hC, 32'hFF00_0000);
    special = 1'b1;
    pulse(7'h20);
    special = 1'b0;
    rd(CS, ST0 | 32'h40);
    wt(1'b1, CS, 4'h1, 32'h0);
    pulse(7'h05);
    check(rpt, 0, "report blocked");
    rd(CS, 32'h82A0_0000);
    wt(1'b1, CS, 4'hC, 32'hFF00_0000);
    $display("test status done");
  endtask

  task automatic t_signalled_system_error();
    pulse(7'h40);
    check({se_oe, se_out_n}, 2'b01, "system error disabled");
    rd(CS, ST0);
    wt(1'b1, CS, 4'h2, 32'h100);
    pulse(7'h02);
    check({se_oe, se_out_n}, 2'b01, "addr parity alone");
    rd(CS, 32'h82A0_0100);
    wt(1'b1, CS, 4'hF, 32'hFF00_0140);
    pulse(7'h02);
    check({se_oe, se_out_n}, 2'b10, "system error driven");
    rd(CS, 32'hC2A0_0140);
    pulse(7'h40);
    check({se_oe, se_out_n}, 2'b10, "request driven");
    // Clear and new parity event land on the same edge
    fork
      wt(1'b1, CS, 4'h8, 32'hC000_0000);
      pulse(7'h01);
    join
    rd(CS, 32'h82A0_0140);
    $display("test system_error done");
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    t_reset();
    t_command();
    t_status();
    t_signalled_system_error();
    complete_run();
  end

  // Tests need about 90 cycles
  initial begin
    #(40 * 2000);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
`default_nettype wire
